// ==== inc/rsrm_defines.svh ====
// register offsets, field positions, reset values and timing counts of the rate sensor map
`ifndef RSRM_DEFINES_SVH
`define RSRM_DEFINES_SVH

// byte addresses of the lower byte; the upper byte sits at the address plus one
`define RSRM_ADDR_FLASH_COUNT 7'h00
`define RSRM_ADDR_SUPPLY 7'h02
`define RSRM_ADDR_RATE 7'h04
`define RSRM_ADDR_RATE_EXT 7'h06
`define RSRM_ADDR_AUX 7'h0a
`define RSRM_ADDR_TEMP 7'h0c
`define RSRM_ADDR_BIAS 7'h14
`define RSRM_ADDR_GAIN 7'h16
`define RSRM_ADDR_ALM1_THR 7'h20
`define RSRM_ADDR_ALM2_THR 7'h22
`define RSRM_ADDR_ALM1_PER 7'h24
`define RSRM_ADDR_ALM2_PER 7'h26
`define RSRM_ADDR_ALM_CFG 7'h28
`define RSRM_ADDR_DAC 7'h30
`define RSRM_ADDR_GPIO 7'h32
`define RSRM_ADDR_MISC 7'h34
`define RSRM_ADDR_PERIOD 7'h36
`define RSRM_ADDR_RANGE 7'h38
`define RSRM_ADDR_SLEEP 7'h3a
`define RSRM_ADDR_DIAG 7'h3c
`define RSRM_ADDR_CMD 7'h3e
`define RSRM_ADDR_LOT_LO 7'h52
`define RSRM_ADDR_LOT_HI 7'h54
`define RSRM_ADDR_PART_ID 7'h56
`define RSRM_ADDR_SERIAL 7'h58

// serial word layout
`define RSRM_FRAME_BITS 16
`define RSRM_FRAME_RW 15
`define RSRM_FRAME_ADDR_HI 14
`define RSRM_FRAME_ADDR_LO 8
`define RSRM_FRAME_DATA_HI 7

// output word layout
`define RSRM_BIT_NEW 15
`define RSRM_BIT_ERR 14
`define RSRM_PERIOD_DEC_HI 3

// reset values
`define RSRM_RST_ZERO 16'h0000
`define RSRM_RST_GAIN 16'h0800
`define RSRM_RST_MISC 16'h0006
`define RSRM_RST_RANGE 16'h0401

// timing: serial clock ceiling and own clock, both in kHz
`define RSRM_SCLK_MAX_KHZ 2500
`define RSRM_CLK_KHZ 100000
`define RSRM_SCLK_HALF_CYC ((`RSRM_CLK_KHZ) / (2 * `RSRM_SCLK_MAX_KHZ))
`define RSRM_SYNC_LAT_CYC 4

`endif

// ==== inc/rsrm_pkg.sv ====
// types shared by the rate sensor register map
package rsrm_pkg;

    // one sample set as delivered by the sample engine
    typedef struct packed {
        logic [13:0] rate;
        logic [15:0] rate_ext;
        logic [11:0] temp;
        logic [11:0] supply;
        logic [11:0] aux;
    } rsrm_sample_s;

    // the writable configuration registers
    typedef struct packed {
        logic [15:0] bias;
        logic [15:0] gain;
        logic [15:0] alm1_thr;
        logic [15:0] alm2_thr;
        logic [15:0] alm1_per;
        logic [15:0] alm2_per;
        logic [15:0] alm_cfg;
        logic [15:0] dac;
        logic [15:0] gpio;
        logic [15:0] misc;
        logic [15:0] period;
        logic [15:0] range_filt;
    } rsrm_ctrl_s;

    // decoded serial request
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } rsrm_req_s;

endpackage

// ==== verilog/rsrm_spi_shift.sv ====
// serial slave shift engine, mode 3, oversampled by the system clock
`timescale 1ns/1ps
`include "rsrm_defines.svh"
module rsrm_spi_shift (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic [15:0] i_tx_word,
    input wire logic i_tx_load,
    output logic [15:0] o_rx_word,
    output logic o_rx_valid,
    output logic o_dout,
    output logic o_dout_oe
);
    logic sclk_s1_r, sclk_s2_r, sclk_d_r;
    logic cs_s1_r, cs_s2_r;
    logic din_s1_r, din_s2_r;
    logic [15:0] rx_sh_r;
    logic [15:0] tx_sh_r;
    logic [3:0] cnt_r;
    logic rise, fall;

    // all three pins go through the same depth so din stays aligned to its edge
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sclk_s1_r <= 1'b1;
            sclk_s2_r <= 1'b1;
            sclk_d_r <= 1'b1;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end
        else
        begin
            sclk_s1_r <= i_sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            din_s1_r <= i_din;
            din_s2_r <= din_s1_r;
        end
    end

    assign rise = sclk_s2_r & ~sclk_d_r & ~cs_s2_r;
    assign fall = ~sclk_s2_r & sclk_d_r & ~cs_s2_r;

    // receive on rising edges; a deselect mid-word drops the partial word
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_sh_r <= 16'h0000;
            cnt_r <= 4'h0;
            o_rx_word <= 16'h0000;
            o_rx_valid <= 1'b0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            if (cs_s2_r)
            begin
                cnt_r <= 4'h0;
            end
            else if (rise)
            begin
                rx_sh_r <= {rx_sh_r[14:0], din_s2_r};
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == 4'hf)
                begin
                    o_rx_word <= {rx_sh_r[14:0], din_s2_r};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    // transmit on falling edges; a load lands well before the next falling edge
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_sh_r <= 16'h0000;
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
        end
        else
        begin
            o_dout_oe <= ~cs_s2_r;
            if (i_tx_load)
            begin
                tx_sh_r <= i_tx_word;
            end
            else if (fall)
            begin
                o_dout <= tx_sh_r[15];
                tx_sh_r <= {tx_sh_r[14:0], 1'b0};
            end
        end
    end
endmodule

// ==== verilog/rsrm_regs.sv ====
// rate sensor user register map behind the serial slave port
//
// Summary of operation
// - each word spans an even and odd byte address
// - bit 15 flags unread sample in outputs except extended rate
// - bit 14 set while diagnostic flags nonzero
// - rate output bits 13..0, two's complement
// - extended rate MSB-justified, decimation setting bits valid
// - temperature in bits 11..0, bits 13..12 zero
// - configuration registers load documented defaults at reset
// - sleep and command write-only; outputs, ids read-only
// - read request answered on data out next word
// - writes carry one byte, odd address upper byte
`timescale 1ns/1ps
`include "rsrm_defines.svh"
module rsrm_regs #(
    parameter int CLK_KHZ = `RSRM_CLK_KHZ,
    parameter logic [15:0] PART_ID = 16'h5a5a // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic i_sample_valid,
    input wire rsrm_pkg::rsrm_sample_s i_sample,
    input wire logic [15:0] i_diag_flags,
    input wire logic [15:0] i_flash_count,
    input wire logic [15:0] i_lot_low,
    input wire logic [15:0] i_lot_high,
    input wire logic [15:0] i_serial,
    output logic o_dout,
    output logic o_dout_oe,
    output rsrm_pkg::rsrm_ctrl_s o_ctrl,
    output logic [15:0] o_sleep_count,
    output logic o_sleep_wr,
    output logic [15:0] o_command,
    output logic o_command_wr
);
    localparam int HALF_CYC = CLK_KHZ / (2 * `RSRM_SCLK_MAX_KHZ);
    localparam int N_FLAG = 4;
    localparam int F_SUPPLY = 0;
    localparam int F_RATE = 1;
    localparam int F_AUX = 2;
    localparam int F_TEMP = 3;

    // the oversampler needs a few clocks per serial half period
    if (HALF_CYC < `RSRM_SYNC_LAT_CYC)
    begin : g_clk_check
        $error("system clock too slow for the serial clock ceiling");
    end

    logic [15:0] rx_word;
    logic rx_valid;
    rsrm_pkg::rsrm_req_s req;
    logic [6:0] word_addr;
    logic rd_req, wr_req;
    logic [15:0] tx_word_r;
    logic tx_load_r;
    rsrm_pkg::rsrm_ctrl_s ctrl_r;
    rsrm_pkg::rsrm_sample_s sample_r;
    logic [N_FLAG-1:0] new_flag_r;
    logic [N_FLAG-1:0] rd_hit;
    logic err_flag;
    logic [15:0] ext_mask;
    logic [15:0] rd_data;
    logic first_r;

    rsrm_spi_shift u_shift (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_din(i_din),
        .i_tx_word(tx_word_r),
        .i_tx_load(tx_load_r),
        .o_rx_word(rx_word),
        .o_rx_valid(rx_valid),
        .o_dout(o_dout),
        .o_dout_oe(o_dout_oe)
    );

    assign req = rsrm_pkg::rsrm_req_s'(rx_word);
    assign word_addr = {req.addr[6:1], 1'b0};
    assign rd_req = rx_valid & ~req.wr;
    assign wr_req = rx_valid & req.wr;
    assign err_flag = |i_diag_flags;
    // keep only as many extension bits as the decimation setting grows
    assign ext_mask = ~(16'hffff >> ctrl_r.period[`RSRM_PERIOD_DEC_HI:0]);

    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    // read mux; reserved and write-only locations answer zero
    always_comb
    begin
        rd_data = 16'h0000;
        case (word_addr)
            `RSRM_ADDR_FLASH_COUNT: rd_data = i_flash_count;
            `RSRM_ADDR_SUPPLY: rd_data = {new_flag_r[F_SUPPLY], err_flag, 2'b00, sample_r.supply};
            `RSRM_ADDR_RATE: rd_data = {new_flag_r[F_RATE], err_flag, sample_r.rate};
            `RSRM_ADDR_RATE_EXT: rd_data = sample_r.rate_ext & ext_mask;
            `RSRM_ADDR_AUX: rd_data = {new_flag_r[F_AUX], err_flag, 2'b00, sample_r.aux};
            `RSRM_ADDR_TEMP: rd_data = {new_flag_r[F_TEMP], err_flag, 2'b00, sample_r.temp};
            `RSRM_ADDR_BIAS: rd_data = ctrl_r.bias;
            `RSRM_ADDR_GAIN: rd_data = ctrl_r.gain;
            `RSRM_ADDR_ALM1_THR: rd_data = ctrl_r.alm1_thr;
            `RSRM_ADDR_ALM2_THR: rd_data = ctrl_r.alm2_thr;
            `RSRM_ADDR_ALM1_PER: rd_data = ctrl_r.alm1_per;
            `RSRM_ADDR_ALM2_PER: rd_data = ctrl_r.alm2_per;
            `RSRM_ADDR_ALM_CFG: rd_data = ctrl_r.alm_cfg;
            `RSRM_ADDR_DAC: rd_data = ctrl_r.dac;
            `RSRM_ADDR_GPIO: rd_data = ctrl_r.gpio;
            `RSRM_ADDR_MISC: rd_data = ctrl_r.misc;
            `RSRM_ADDR_PERIOD: rd_data = ctrl_r.period;
            `RSRM_ADDR_RANGE: rd_data = ctrl_r.range_filt;
            `RSRM_ADDR_DIAG: rd_data = i_diag_flags;
            `RSRM_ADDR_LOT_LO: rd_data = i_lot_low;
            `RSRM_ADDR_LOT_HI: rd_data = i_lot_high;
            `RSRM_ADDR_PART_ID: rd_data = PART_ID;
            `RSRM_ADDR_SERIAL: rd_data = i_serial;
            default: rd_data = 16'h0000;
        endcase
    end

    // answer word for the next serial word; after a write the next word shifts zeros
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_word_r <= 16'h0000;
            tx_load_r <= 1'b0;
        end
        else
        begin
            tx_load_r <= rx_valid;
            if (rx_valid)
            begin
                tx_word_r <= rd_req ? rd_data : 16'h0000;
            end
        end
    end

    // sample capture from the sample engine
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sample_r <= '0;
        end
        else if (i_sample_valid)
        begin
            sample_r <= i_sample;
        end
    end

    assign rd_hit[F_SUPPLY] = rd_req && word_addr == `RSRM_ADDR_SUPPLY;
    assign rd_hit[F_RATE] = rd_req && word_addr == `RSRM_ADDR_RATE;
    assign rd_hit[F_AUX] = rd_req && word_addr == `RSRM_ADDR_AUX;
    assign rd_hit[F_TEMP] = rd_req && word_addr == `RSRM_ADDR_TEMP;

    // unread flags: a sample landing with a read keeps the flag set
    for (genvar g = 0; g < N_FLAG; g++)
    begin : g_flag
        always_ff @(posedge i_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                new_flag_r[g] <= 1'b0;
            end
            else if (i_sample_valid)
            begin
                new_flag_r[g] <= 1'b1;
            end
            else if (rd_hit[g])
            begin
                new_flag_r[g] <= 1'b0;
            end
        end
    end

    // configuration writes, one byte at a time; read-only targets are ignored
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_r.bias <= `RSRM_RST_ZERO;
            ctrl_r.gain <= `RSRM_RST_GAIN;
            ctrl_r.alm1_thr <= `RSRM_RST_ZERO;
            ctrl_r.alm2_thr <= `RSRM_RST_ZERO;
            ctrl_r.alm1_per <= `RSRM_RST_ZERO;
            ctrl_r.alm2_per <= `RSRM_RST_ZERO;
            ctrl_r.alm_cfg <= `RSRM_RST_ZERO;
            ctrl_r.dac <= `RSRM_RST_ZERO;
            ctrl_r.gpio <= `RSRM_RST_ZERO;
            ctrl_r.misc <= `RSRM_RST_MISC;
            ctrl_r.period <= `RSRM_RST_ZERO;
            ctrl_r.range_filt <= `RSRM_RST_RANGE;
        end
        else if (wr_req)
        begin
            case (word_addr)
                `RSRM_ADDR_BIAS: ctrl_r.bias <= put_byte(ctrl_r.bias, req.addr[0], req.data);
                `RSRM_ADDR_GAIN: ctrl_r.gain <= put_byte(ctrl_r.gain, req.addr[0], req.data);
                `RSRM_ADDR_ALM1_THR:
                    ctrl_r.alm1_thr <= put_byte(ctrl_r.alm1_thr, req.addr[0], req.data);
                `RSRM_ADDR_ALM2_THR:
                    ctrl_r.alm2_thr <= put_byte(ctrl_r.alm2_thr, req.addr[0], req.data);
                `RSRM_ADDR_ALM1_PER:
                    ctrl_r.alm1_per <= put_byte(ctrl_r.alm1_per, req.addr[0], req.data);
                `RSRM_ADDR_ALM2_PER:
                    ctrl_r.alm2_per <= put_byte(ctrl_r.alm2_per, req.addr[0], req.data);
                `RSRM_ADDR_ALM_CFG:
                    ctrl_r.alm_cfg <= put_byte(ctrl_r.alm_cfg, req.addr[0], req.data);
                `RSRM_ADDR_DAC: ctrl_r.dac <= put_byte(ctrl_r.dac, req.addr[0], req.data);
                `RSRM_ADDR_GPIO: ctrl_r.gpio <= put_byte(ctrl_r.gpio, req.addr[0], req.data);
                `RSRM_ADDR_MISC: ctrl_r.misc <= put_byte(ctrl_r.misc, req.addr[0], req.data);
                `RSRM_ADDR_PERIOD:
                    ctrl_r.period <= put_byte(ctrl_r.period, req.addr[0], req.data);
                `RSRM_ADDR_RANGE:
                    ctrl_r.range_filt <= put_byte(ctrl_r.range_filt, req.addr[0], req.data);
                default:
                begin
                end
            endcase
        end
    end

    assign o_ctrl = ctrl_r;

    // write-only locations: held for the consumer, strobed once per byte
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sleep_count <= 16'h0000;
            o_sleep_wr <= 1'b0;
            o_command <= 16'h0000;
            o_command_wr <= 1'b0;
        end
        else
        begin
            o_sleep_wr <= wr_req && word_addr == `RSRM_ADDR_SLEEP;
            o_command_wr <= wr_req && word_addr == `RSRM_ADDR_CMD;
            if (wr_req && word_addr == `RSRM_ADDR_SLEEP)
            begin
                o_sleep_count <= put_byte(o_sleep_count, req.addr[0], req.data);
            end
            if (wr_req && word_addr == `RSRM_ADDR_CMD)
            begin
                o_command <= put_byte(o_command, req.addr[0], req.data);
            end
        end
    end

    // marks the first clock after reset release, for checking only
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            first_r <= 1'b1;
        end
        else
        begin
            first_r <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_flag_on_sample: assert property (i_sample_valid |=> &new_flag_r)
        else $error("unread flags not set by a new sample");
    a_flag_clear_read: assert property (rd_hit[F_RATE] && !i_sample_valid
        ##1 !i_sample_valid |-> !new_flag_r[F_RATE] ##1 !new_flag_r[F_RATE])
        else $error("rate unread flag not cleared by its read");
    // with neither a sample nor a read, an unread flag keeps its value
    a_flag_holds: assert property (!i_sample_valid && !rd_hit[F_TEMP]
        |=> $stable(new_flag_r[F_TEMP]))
        else $error("temperature unread flag changed with no event");
    // answer words land one clock after the request word is taken
    a_err_in_answer: assert property (rd_hit[F_TEMP]
        |=> tx_load_r && tx_word_r[`RSRM_BIT_ERR] == $past(err_flag))
        else $error("error bit in answer does not follow diagnostic flags");
    a_rate_answer: assert property (rd_hit[F_RATE]
        |=> tx_word_r == {$past(new_flag_r[F_RATE]), $past(err_flag), $past(sample_r.rate)})
        else $error("rate answer word malformed");
    a_supply_answer: assert property (rd_hit[F_SUPPLY]
        |=> tx_word_r == {$past(new_flag_r[F_SUPPLY]), $past(|i_diag_flags), 2'b00,
        $past(sample_r.supply)})
        else $error("supply answer word malformed");
    a_aux_answer: assert property (rd_hit[F_AUX]
        |=> tx_word_r[`RSRM_BIT_ERR] == $past(|i_diag_flags) && tx_word_r[13:12] == 2'b00)
        else $error("auxiliary answer word malformed");
    a_diag_answer: assert property (rx_valid && !req.wr && word_addr == `RSRM_ADDR_DIAG
        |=> tx_word_r == $past(i_diag_flags))
        else $error("diagnostic flags answer wrong");
    a_ext_masked: assert property (rx_valid && !req.wr && word_addr == `RSRM_ADDR_RATE_EXT
        |=> (tx_word_r & ~$past(ext_mask)) == 16'h0000)
        else $error("extension bits beyond decimation setting");
    a_ext_no_growth: assert property (
        rx_valid && !req.wr && word_addr == `RSRM_ADDR_RATE_EXT
        && ctrl_r.period[`RSRM_PERIOD_DEC_HI:0] == 4'h0 |=> tx_word_r == 16'h0000)
        else $error("extension bits read with no decimation");
    a_temp_unused: assert property (rd_hit[F_TEMP] |=> tx_word_r[13:12] == 2'b00)
        else $error("temperature unused bits not zero");
    a_reset_defaults: assert property (first_r |-> ctrl_r.gain == `RSRM_RST_GAIN
        && ctrl_r.misc == `RSRM_RST_MISC && ctrl_r.range_filt == `RSRM_RST_RANGE
        && ctrl_r.bias == `RSRM_RST_ZERO && ctrl_r.period == `RSRM_RST_ZERO)
        else $error("configuration defaults wrong after reset");
    a_wo_reads_zero: assert property (rx_valid && !req.wr
        && (word_addr == `RSRM_ADDR_SLEEP || word_addr == `RSRM_ADDR_CMD)
        |=> tx_load_r && tx_word_r == 16'h0000)
        else $error("write-only location read back nonzero");
    a_part_id_answer: assert property (
        rx_valid && !req.wr && word_addr == `RSRM_ADDR_PART_ID |=> tx_word_r == PART_ID)
        else $error("part identifier answer wrong");
    a_ro_ignores_write: assert property (wr_req && word_addr == `RSRM_ADDR_RATE
        && !i_sample_valid |=> $stable(sample_r))
        else $error("read-only output changed by a write");
    a_upper_byte_lane: assert property (wr_req && word_addr == `RSRM_ADDR_GAIN
        && req.addr[0] |=> ctrl_r.gain[15:8] == $past(req.data) && $stable(ctrl_r.gain[7:0]))
        else $error("upper byte write landed in the wrong lane");
    a_lower_byte_lane: assert property (wr_req && word_addr == `RSRM_ADDR_GAIN
        && !req.addr[0] |=> ctrl_r.gain[7:0] == $past(req.data) && $stable(ctrl_r.gain[15:8]))
        else $error("lower byte write landed in the wrong lane");
    a_sleep_strobe: assert property (wr_req && word_addr == `RSRM_ADDR_SLEEP
        |=> o_sleep_wr && !o_command_wr)
        else $error("sleep location write not strobed");
    a_cmd_strobe: assert property (wr_req && word_addr == `RSRM_ADDR_CMD && req.addr[0]
        |=> o_command_wr && o_command[15:8] == $past(req.data))
        else $error("command upper byte not strobed");
    a_write_no_answer: assert property (wr_req |=> tx_load_r && tx_word_r == 16'h0000)
        else $error("word after a write does not shift zeros");

    c_read_rate: cover property (rd_hit[F_RATE] && new_flag_r[F_RATE]);
    c_write_gain: cover property (wr_req && word_addr == `RSRM_ADDR_GAIN);
    c_read_collide: cover property (rd_hit[F_RATE] && i_sample_valid);
    c_write_command: cover property (o_command_wr);
    c_read_ext: cover property (rx_valid && !req.wr && word_addr == `RSRM_ADDR_RATE_EXT);
endmodule

// ==== tb/rsrm_spi_master.sv ====
// serial master model that drives mode 3 words into the register map
`timescale 1ns/1ps
module rsrm_spi_master #(
    parameter int HALF_NS = 200
) (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din,
    input wire logic i_miso
);
    initial
    begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end

    // clock is kept at the 2.5 MHz ceiling, since the device oversamples it
    // with its own clock and a faster one would be out of contract
    task automatic xfer(input logic [15:0] tx, input int gap_ns, output logic [15:0] rx);
        o_cs_n = 1'b0;
        #(HALF_NS);
        for (int i = 15; i >= 0; i--)
        begin
            o_sclk = 1'b0;
            o_din = tx[i];
            #(HALF_NS);
            o_sclk = 1'b1;
            rx[i] = i_miso;
            #(HALF_NS);
        end
        // a released line must not keep showing its last bit
        o_cs_n = 1'b1;
        o_din = ~o_din;
        #(gap_ns);
    endtask
endmodule

// ==== tb/rate_sensor_register_map_bench.sv ====
// self-checking bench for the rate sensor register map
`timescale 1ns/1ps
`include "rsrm_defines.svh"
module rate_sensor_register_map_bench;
    localparam logic [15:0] PART_ID_VAL = 16'h1c3e; // arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe, miso;
    logic miso_hold = 1'b0;
    logic smp_valid = 1'b0;
    rsrm_pkg::rsrm_sample_s smp = '0;
    logic [15:0] diag = 16'h0000;
    logic [15:0] serial = 16'h9c31;
    logic [15:0] sleep_count, command;
    logic sleep_wr, command_wr;
    rsrm_pkg::rsrm_ctrl_s ctrl;
    int n_fail = 0;
    int cmp_count = 0;
    int sleep_pulses = 0;
    int cmd_pulses = 0;

    always #5 clk = ~clk;

    // no pull on the data-out wire: a floating line shows the inverse of its last bit
    always @(posedge clk)
    begin
        if (dout_oe === 1'b1)
            miso_hold <= dout;
        if (sleep_wr === 1'b1)
            sleep_pulses++;
        if (command_wr === 1'b1)
            cmd_pulses++;
    end
    assign miso = (dout_oe === 1'b1) ? dout : ~miso_hold;

    rsrm_spi_master i_master (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_miso(miso));

    rsrm_regs #(.PART_ID(PART_ID_VAL)) i_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
        .i_sample_valid(smp_valid), .i_sample(smp), .i_diag_flags(diag),
        .i_flash_count(16'h0021), .i_lot_low(16'h4411), .i_lot_high(16'h4422),
        .i_serial(serial), .o_dout(dout), .o_dout_oe(dout_oe), .o_ctrl(ctrl),
        .o_sleep_count(sleep_count), .o_sleep_wr(sleep_wr), .o_command(command),
        .o_command_wr(command_wr)
    );

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] rx;
        i_master.xfer({1'b1, a, d}, 400, rx);
    endtask

    // request word, then a flash-count request that carries the answer back
    task automatic rd(input logic [6:0] a, output logic [15:0] v);
        logic [15:0] rx;
        i_master.xfer({1'b0, a, 8'h00}, 400, rx);
        i_master.xfer(16'h0000, 40, v);
    endtask

    task automatic load_sample(input logic [13:0] r, input logic [15:0] x, input logic [11:0] t);
        @(posedge clk);
        #1;
        smp = {r, x, t, 12'haaa, 12'h001};
        smp_valid = 1'b1;
        @(posedge clk);
        #1;
        smp_valid = 1'b0;
    endtask

    task automatic t_defaults();
        logic [6:0] addrs [12];
        logic [15:0] exps [12];
        logic [15:0] v;
        addrs = '{7'h14, 7'h16, 7'h20, 7'h22, 7'h24, 7'h26, 7'h28, 7'h30, 7'h32, 7'h34,
                  7'h36, 7'h38};
        exps = '{16'h0000, 16'h0800, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                 16'h0000, 16'h0000, 16'h0006, 16'h0000, 16'h0401};
        check(ctrl.range_filt, 16'h0401);
        for (int i = 0; i < 12; i++)
        begin
            // odd entries use the upper-byte address of the same word
            rd(addrs[i] | 7'(i & 1), v);
            check(v, exps[i]);
        end
    endtask

    task automatic t_bytes();
        logic [15:0] v;
        wr(`RSRM_ADDR_GAIN, 8'h34);
        wr(`RSRM_ADDR_GAIN + 7'h01, 8'h12);
        check(ctrl.gain, 16'h1234);
        wr(`RSRM_ADDR_GAIN + 7'h01, 8'hab);
        check(ctrl.gain, 16'hab34);
        rd(`RSRM_ADDR_GAIN + 7'h01, v);
        check(v, 16'hab34);
        check(ctrl.misc, 16'h0006);
    endtask

    task automatic t_access();
        logic [15:0] v;
        wr(`RSRM_ADDR_PART_ID, 8'h00);
        wr(`RSRM_ADDR_RATE, 8'h55);
        rd(`RSRM_ADDR_PART_ID, v);
        check(v, PART_ID_VAL);
        rd(`RSRM_ADDR_RATE, v);
        check(v, 16'h0000);
        rd(`RSRM_ADDR_SERIAL + 7'h01, v);
        check(v, serial);
        rd(`RSRM_ADDR_FLASH_COUNT, v);
        check(v, 16'h0021);
        wr(`RSRM_ADDR_SLEEP, 8'h07);
        check(sleep_count, 16'h0007);
        check(16'(sleep_pulses), 16'h0001);
        rd(`RSRM_ADDR_SLEEP, v);
        check(v, 16'h0000);
        wr(`RSRM_ADDR_CMD + 7'h01, 8'h80);
        check(command, 16'h8000);
        check(16'(cmd_pulses), 16'h0001);
        rd(`RSRM_ADDR_CMD, v);
        check(v, 16'h0000);
    endtask

    task automatic t_sample();
        logic [15:0] v;
        load_sample(14'h2000, 16'hffff, 12'h800);
        rd(`RSRM_ADDR_RATE, v);
        check(v, 16'ha000);
        rd(`RSRM_ADDR_RATE, v);
        check(v, 16'h2000);
        rd(`RSRM_ADDR_TEMP, v);
        check(v, 16'h8800);
        rd(`RSRM_ADDR_RATE_EXT, v);
        check(v, 16'h0000);
        diag = 16'h0010;
        rd(`RSRM_ADDR_SUPPLY, v);
        check(v, 16'hcaaa);
        rd(`RSRM_ADDR_DIAG, v);
        check(v, 16'h0010);
        rd(`RSRM_ADDR_AUX + 7'h01, v);
        check(v, 16'hc001);
        rd(`RSRM_ADDR_TEMP, v);
        check(v, 16'h4800);
        diag = 16'h0000;
        wr(`RSRM_ADDR_PERIOD, 8'h04);
        load_sample(14'h1fff, 16'h5555, 12'h7ff);
        rd(`RSRM_ADDR_RATE_EXT, v);
        check(v, 16'h5000);
        rd(`RSRM_ADDR_RATE, v);
        check(v, 16'h9fff);
    endtask

    // reset in mid-run must bring the written registers back to their defaults
    task automatic t_reset();
        logic [15:0] v;
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(ctrl.gain, 16'h0800);
        check(ctrl.period, 16'h0000);
        rd(`RSRM_ADDR_RATE, v);
        check(v, 16'h0000);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        // every later pin change then stays 1 ns past a clock edge
        #1;
        t_defaults();
        t_bytes();
        t_access();
        t_sample();
        t_reset();
        conclude();
    end

    // about 70 words of 7 us each are expected; allow about twice that
    initial
    begin
        #900000;
        n_fail++;
        conclude();
    end
endmodule
